//--- tape_bus_if.sv
// Expansion-bus I/O window between the host side and the tape port
interface tape_bus_if;
  logic [9:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic bus_power_on_reset;
  logic irq_out;
  logic irq_oe;
  modport device (input io_addr, io_wr, io_rd, io_wdata, bus_power_on_reset,
    output io_rdata, irq_out, irq_oe);
  modport host (output io_addr, io_wr, io_rd, io_wdata, bus_power_on_reset,
    input io_rdata, irq_out, irq_oe);
endinterface : tape_bus_if

//--- tape_ctrl_host_port.sv
// Device end: I/O window decode, control and status registers, DMA strobes, command decode
//
// Register access over AHB-Lite was left to the implementer.
module tape_ctrl_host_port
  import tape_port_pkg::*;
#(
  parameter logic [9:0] BASE = BASE_DEFAULT
) (
  input wire logic clock,
  input wire logic arst_n,
  tape_bus_if.device bus,
  input wire logic chip_ready,
  input wire logic chip_exception,
  input wire logic chip_direction,
  input wire logic [7:0] chip_rdata,
  input wire logic dma_block_done,
  input wire logic early_warning,
  input wire logic filemark_seen,
  output logic cpu_reset,
  output logic cmd_request,
  output logic [7:0] cmd_byte_ff,
  output logic cmd_strobe_ff,
  output logic dma_launch_strobe,
  output logic dma_init_strobe,
  output logic dma_active_ff,
  output logic drive_selected_ff,
  output logic cartridge_locked_ff,
  output logic wind_bot_ff,
  output logic retension_ff,
  output logic erase_ff,
  output logic writing_ff,
  output logic reading_ff,
  output logic end_of_media_ff,
  output logic at_bot_pending_ff
);
  logic [7:0] ctrl_ff;
  logic done_ff;
  logic [7:0] rdata_ff;
  logic exc_ev_ff;
  logic sel_hit;
  logic wr_data, wr_ctrl, rd_data, rd_stat;
  logic init_all;
  logic int_pending_flag;
  logic [7:0] status;

  function automatic logic hit(input logic [9:0] a, input logic [2:0] ofs);
    return (a[9:3] == BASE[9:3]) && (a[2:0] == ofs);
  endfunction : hit

  assign wr_data = bus.io_wr && hit(bus.io_addr, OFS_DATA);
  assign wr_ctrl = bus.io_wr && hit(bus.io_addr, OFS_CTRL_STAT);
  assign rd_data = bus.io_rd && hit(bus.io_addr, OFS_DATA);
  assign rd_stat = bus.io_rd && hit(bus.io_addr, OFS_CTRL_STAT);
  assign dma_launch_strobe = bus.io_wr && hit(bus.io_addr, OFS_DMA_LAUNCH);
  assign dma_init_strobe = bus.io_wr && hit(bus.io_addr, OFS_DMA_INIT);
  assign init_all = dma_init_strobe || bus.bus_power_on_reset;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= CTRL_RESET;
    end else if (init_all) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= {bus.io_wdata[7:4], 4'h0};
    end
  end

  assign cpu_reset = ctrl_ff[CPU_RESET_BIT_POS];
  assign cmd_request = ctrl_ff[REQ_BIT_POS];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      done_ff <= 1'b1;
      dma_active_ff <= 1'b0;
    end else if (init_all) begin
      done_ff <= 1'b1;
      dma_active_ff <= 1'b0;
    end else if (dma_launch_strobe) begin
      done_ff <= 1'b0;
      dma_active_ff <= 1'b1;
    end else if (dma_block_done) begin
      done_ff <= 1'b1;
      dma_active_ff <= 1'b0;
    end
  end

  assign int_pending_flag = chip_ready || chip_exception || exc_ev_ff ||
    (done_ff && ctrl_ff[DONE_IRQ_EN_POS]);
  // done gating is in the flag; mask and release the line
  assign bus.irq_out = ctrl_ff[IRQ_EN_POS] && int_pending_flag;
  assign bus.irq_oe = ctrl_ff[IRQ_EN_POS];

  always_comb begin
    status = 8'h00;
    status[ST_INT_PENDING_FLAG_POS] = int_pending_flag;
    status[ST_READY_POS] = chip_ready;
    status[ST_EXC_POS] = chip_exception || exc_ev_ff;
    status[ST_DONE_POS] = done_ff;
    status[ST_DIR_POS] = chip_direction;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else if (rd_stat) begin
      rdata_ff <= status;
    end else if (rd_data) begin
      // controller byte only when direction is toward host
      rdata_ff <= chip_direction ? chip_rdata : 8'h00;
    end
  end
  assign bus.io_rdata = rdata_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_byte_ff <= 8'h00;
      cmd_strobe_ff <= 1'b0;
    end else begin
      // latch command when bus points at the controller
      cmd_strobe_ff <= wr_data && !chip_direction;
      if (wr_data && !chip_direction) begin
        cmd_byte_ff <= bus.io_wdata;
      end
    end
  end

  // Command execution state; the drive reset also clears it, except at_bot_pending_ff, which it sets
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      drive_selected_ff <= 1'b0;
      cartridge_locked_ff <= 1'b0;
      wind_bot_ff <= 1'b0;
      retension_ff <= 1'b0;
      erase_ff <= 1'b0;
      writing_ff <= 1'b0;
      reading_ff <= 1'b0;
      end_of_media_ff <= 1'b0;
      exc_ev_ff <= 1'b0;
      at_bot_pending_ff <= 1'b1;
    end else if (cpu_reset) begin
      drive_selected_ff <= 1'b0;
      cartridge_locked_ff <= 1'b0;
      wind_bot_ff <= 1'b0;
      retension_ff <= 1'b0;
      erase_ff <= 1'b0;
      writing_ff <= 1'b0;
      reading_ff <= 1'b0;
      end_of_media_ff <= 1'b0;
      exc_ev_ff <= 1'b0;
      at_bot_pending_ff <= 1'b1;
    end else begin
      wind_bot_ff <= 1'b0;
      retension_ff <= 1'b0;
      erase_ff <= 1'b0;
      if (rd_stat) begin
        exc_ev_ff <= 1'b0;
      end
      if (writing_ff && early_warning) begin
        writing_ff <= 1'b0;
        end_of_media_ff <= 1'b1;
        exc_ev_ff <= 1'b1;
      end
      if (reading_ff && filemark_seen) begin
        reading_ff <= 1'b0;
        exc_ev_ff <= 1'b1;
      end
      if (cmd_strobe_ff) begin
        case (cmd_byte_ff)
          CMD_SELECT: begin
            drive_selected_ff <= 1'b1;
            cartridge_locked_ff <= 1'b0;
          end
          CMD_SELECT_LOCK: begin
            drive_selected_ff <= 1'b1;
            cartridge_locked_ff <= 1'b1;
          end
          CMD_BOT: wind_bot_ff <= drive_selected_ff;
          CMD_RETENSION: retension_ff <= drive_selected_ff;
          CMD_ERASE: begin
            erase_ff <= drive_selected_ff;
            at_bot_pending_ff <= 1'b1;
          end
          CMD_WRITE: begin
            writing_ff <= 1'b1;
            reading_ff <= 1'b0;
            end_of_media_ff <= 1'b0;
            at_bot_pending_ff <= 1'b0;
          end
          CMD_FILEMARK_WRITE: begin
            if (chip_ready) begin
              writing_ff <= 1'b0;
            end
          end
          CMD_READ: begin
            reading_ff <= 1'b1;
            writing_ff <= 1'b0;
            at_bot_pending_ff <= 1'b0;
          end
          CMD_FILEMARK_SEEK: begin
            if (chip_ready) begin
              reading_ff <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule : tape_ctrl_host_port

//--- tape_host_end.sv
// Host end: AHB-Lite slave that turns software orders into I/O window cycles
module tape_host_end
  import tape_port_pkg::*;
#(
  parameter logic [9:0] BASE = BASE_DEFAULT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  tape_bus_if.host bus
);
  typedef enum logic [1:0] {S_IDLE, S_DATA, S_CYCLE, S_DONE} st_type;
  st_type st_ff;
  logic ph_valid_ff, ph_write_ff;
  logic [7:0] ph_addr_ff;
  logic [9:0] io_addr_ff;
  logic io_wr_ff, io_rd_ff;
  logic [7:0] io_wdata_ff;
  logic [7:0] last_rd_ff;
  logic por_ff;
  logic [31:0] hrdata_ff;

  assign hresp = 1'b0;
  // Wait states begin in the first data-phase cycle, so hrdata is never taken stale
  assign hreadyout = (st_ff == S_IDLE) && !ph_valid_ff;
  assign hrdata = hrdata_ff;
  assign bus.io_addr = io_addr_ff;
  assign bus.io_wr = io_wr_ff;
  assign bus.io_rd = io_rd_ff;
  assign bus.io_wdata = io_wdata_ff;
  assign bus.bus_power_on_reset = por_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= S_IDLE;
      ph_valid_ff <= 1'b0;
      ph_write_ff <= 1'b0;
      ph_addr_ff <= 8'h00;
      io_addr_ff <= 10'h000;
      io_wr_ff <= 1'b0;
      io_rd_ff <= 1'b0;
      io_wdata_ff <= 8'h00;
      last_rd_ff <= 8'h00;
      por_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      io_wr_ff <= 1'b0;
      io_rd_ff <= 1'b0;
      por_ff <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (ph_valid_ff) begin
            st_ff <= S_DATA;
          end else begin
            // Address phase is only captured while no transfer is pending
            ph_valid_ff <= hsel && hready && (htrans == HTRANS_NONSEQ);
            ph_write_ff <= hwrite;
            ph_addr_ff <= haddr;
          end
        end
        S_DATA: begin
          ph_valid_ff <= 1'b0;
          if (ph_addr_ff == AHB_OFS_STATUS || ph_addr_ff == AHB_OFS_DATA) begin
            // Status and data reads and writes go out to the window
            io_addr_ff <= BASE + {7'h00, (ph_addr_ff == AHB_OFS_STATUS) ? OFS_CTRL_STAT : OFS_DATA};
            io_rd_ff <= !ph_write_ff;
            io_wr_ff <= ph_write_ff;
            io_wdata_ff <= hwdata[7:0];
            st_ff <= S_CYCLE;
          end else if (ph_addr_ff == AHB_OFS_CMD && ph_write_ff) begin
            // Low bits pick the window location, next byte the value
            io_addr_ff <= BASE + {7'h00, hwdata[2:0]};
            io_wdata_ff <= hwdata[15:8];
            io_wr_ff <= 1'b1;
            st_ff <= S_CYCLE;
          end else if (ph_addr_ff == AHB_OFS_CTRL && ph_write_ff) begin
            por_ff <= hwdata[0];
            st_ff <= S_DONE;
          end else begin
            hrdata_ff <= {24'h000000, last_rd_ff};
            st_ff <= S_DONE;
          end
        end
        S_CYCLE: begin
          st_ff <= S_DONE;
        end
        S_DONE: begin
          if (!ph_write_ff && ph_addr_ff != AHB_OFS_CMD && ph_addr_ff != AHB_OFS_CTRL) begin
            last_rd_ff <= bus.io_rdata;
            hrdata_ff <= {24'h000000, bus.io_rdata};
          end
          st_ff <= S_IDLE;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule : tape_host_end

//--- tape_port_monitor.sv
// Concurrent checks on the I/O window between host end and tape port
module tape_port_monitor
  import tape_port_pkg::*;
#(
  parameter logic [9:0] BASE = BASE_DEFAULT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [9:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic bus_power_on_reset,
  input wire logic irq_out,
  input wire logic irq_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic den_ff;
  logic fresh_ff;
  wire ctl_wr = io_wr && io_addr == BASE + 10'h1;
  wire go_wr = io_wr && io_addr == BASE + 10'h2;
  wire init_ev = bus_power_on_reset || (io_wr && io_addr == BASE + 10'h3);
  wire st_rd = io_rd && io_addr == BASE + 10'h1;
  // Mirror of the done enable, since the flag depends on it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) den_ff <= 1'b0;
    else if (init_ev) den_ff <= 1'b0;
    else if (ctl_wr) den_ff <= io_wdata[4];
  end
  // Done may only be relied on until a launch restarts the sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) fresh_ff <= 1'b1;
    else if (init_ev) fresh_ff <= 1'b1;
    else if (go_wr) fresh_ff <= 1'b0;
  end
  sequence s_ctl_on;
    ctl_wr && io_wdata[5] && !init_ev;
  endsequence
  sequence s_stat_rd;
    st_rd;
  endsequence
  property p_irq_on; s_ctl_on |=> irq_oe; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq line not driven after enable");
  property p_irq_off; ctl_wr && !io_wdata[5] && !init_ev |=> !irq_oe; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq line driven while masked");
  property p_irq_quiet; !irq_oe |-> !irq_out; endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq asserted while released");
  property p_init_off; init_ev |=> !irq_oe; endproperty
  a_init_off: assert property (p_init_off) else $error("control not cleared by init");
  property p_launch_keep; go_wr && irq_oe && !init_ev |=> irq_oe; endproperty
  a_launch_keep: assert property (p_launch_keep) else $error("launch write changed control");
  property p_unused;
    io_wr && io_addr >= BASE + 10'h4 && io_addr <= BASE + 10'h7 && !bus_power_on_reset |=> $stable(irq_oe);
  endproperty
  a_unused: assert property (p_unused) else $error("unused location changed control");
  property p_stat_zero; s_stat_rd |=> io_rdata[2:0] == 3'h0; endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("unused status bits set");
  property p_flag;
    s_stat_rd |=> io_rdata[7] == (io_rdata[6] || io_rdata[5] || (io_rdata[4] && $past(den_ff)));
  endproperty
  a_flag: assert property (p_flag) else $error("interrupt flag not the gated or");
  property p_done_fresh; s_stat_rd and fresh_ff |=> io_rdata[4]; endproperty
  a_done_fresh: assert property (p_done_fresh) else $error("done not set after init");
endmodule : tape_port_monitor

//--- tape_port_pkg.sv
// Shared constants for the tape controller host port
package tape_port_pkg;
  localparam logic [9:0] BASE_DEFAULT = 10'h200;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_CTRL_STAT = 3'h1;
  localparam logic [2:0] OFS_DMA_LAUNCH = 3'h2;
  localparam logic [2:0] OFS_DMA_INIT = 3'h3;
  localparam int CPU_RESET_BIT_POS = 7;
  localparam int REQ_BIT_POS = 6;
  localparam int IRQ_EN_POS = 5;
  localparam int DONE_IRQ_EN_POS = 4;
  localparam int ST_INT_PENDING_FLAG_POS = 7;
  localparam int ST_READY_POS = 6;
  localparam int ST_EXC_POS = 5;
  localparam int ST_DONE_POS = 4;
  localparam int ST_DIR_POS = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CMD_SELECT = 8'h01;
  localparam logic [7:0] CMD_SELECT_LOCK = 8'h11;
  localparam logic [7:0] CMD_BOT = 8'h21;
  localparam logic [7:0] CMD_ERASE = 8'h22;
  localparam logic [7:0] CMD_RETENSION = 8'h24;
  localparam logic [7:0] CMD_WRITE = 8'h40;
  localparam logic [7:0] CMD_FILEMARK_WRITE = 8'h60;
  localparam logic [7:0] CMD_READ = 8'h80;
  localparam logic [7:0] CMD_FILEMARK_SEEK = 8'ha0;
  localparam real CPU_RESET_HOLD_US = 25.0;
  localparam real CLOCK_MHZ = 250.0;
  localparam int CPU_RESET_HOLD_CYC = int'(CPU_RESET_HOLD_US * CLOCK_MHZ) + 1;
  localparam logic [7:0] AHB_OFS_CMD = 8'h00;
  localparam logic [7:0] AHB_OFS_STATUS = 8'h04;
  localparam logic [7:0] AHB_OFS_DATA = 8'h08;
  localparam logic [7:0] AHB_OFS_CTRL = 8'h0c;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  typedef enum logic [1:0] {OP_READ, OP_WRITE} op_type;
endpackage : tape_port_pkg

//--- tb.sv
// Self-checking bench: AHB master driving the host end, device end facing it
module tb
  import tape_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic chip_ready = 1'b0;
  logic chip_exception = 1'b0;
  logic chip_direction = 1'b0;
  logic [7:0] chip_rdata = 8'h00;
  logic dma_block_done = 1'b0;
  logic early_warning = 1'b0;
  logic filemark_seen = 1'b0;
  logic cpu_reset, cmd_request, cmd_strobe_ff, dma_launch_strobe, dma_init_strobe, dma_active_ff;
  logic drive_selected_ff, cartridge_locked_ff, wind_bot_ff, retension_ff, erase_ff;
  logic writing_ff, reading_ff, end_of_media_ff, at_bot_pending_ff;
  logic [7:0] cmd_byte_ff;
  logic [31:0] rd;
  int n_mismatch = 0;
  int cmp_count = 0;
  int pulse_cnt [5] = '{default: 0};
  wire [4:0] pl = {erase_ff, retension_ff, wind_bot_ff, dma_init_strobe, dma_launch_strobe};
  tape_bus_if u_tape_bus_if ();
  tape_ctrl_host_port u_tape_ctrl_host_port (.clock, .arst_n, .bus(u_tape_bus_if.device), .chip_ready,
    .chip_exception, .chip_direction, .chip_rdata, .dma_block_done, .early_warning, .filemark_seen,
    .cpu_reset, .cmd_request, .cmd_byte_ff, .cmd_strobe_ff, .dma_launch_strobe, .dma_init_strobe,
    .dma_active_ff, .drive_selected_ff, .cartridge_locked_ff, .wind_bot_ff, .retension_ff, .erase_ff,
    .writing_ff, .reading_ff, .end_of_media_ff, .at_bot_pending_ff);
  tape_host_end u_tape_host_end (.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .bus(u_tape_bus_if.host));
  tape_port_monitor u_tape_port_monitor (.clock, .arst_n, .io_addr(u_tape_bus_if.io_addr),
    .io_wr(u_tape_bus_if.io_wr), .io_rd(u_tape_bus_if.io_rd), .io_wdata(u_tape_bus_if.io_wdata),
    .io_rdata(u_tape_bus_if.io_rdata), .bus_power_on_reset(u_tape_bus_if.bus_power_on_reset),
    .irq_out(u_tape_bus_if.irq_out), .irq_oe(u_tape_bus_if.irq_oe));
  always #2 clock = ~clock;
  always @(posedge clock) begin
    for (int i = 0; i < 5; i++) if (pl[i] === 1'b1) pulse_cnt[i]++;
  end
  task summarize;
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Entered just after a rising edge; holds each phase until hready
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask : xfer
  task port_wr(input logic [2:0] loc, input logic [7:0] b);
    xfer(1'b1, AHB_OFS_CMD, {16'h0000, b, 5'h00, loc});
    repeat (4) @(posedge clock);
  endtask : port_wr
  task rd_stat(input string nm, input logic [7:0] e);
    xfer(1'b0, AHB_OFS_STATUS, 32'h0);
    chk(nm, e, rd[7:0]);
  endtask : rd_stat
  task pulse_in(input int which);
    if (which == 0) early_warning <= 1'b1;
    else if (which == 1) filemark_seen <= 1'b1;
    else dma_block_done <= 1'b1;
    @(posedge clock);
    {early_warning, filemark_seen, dma_block_done} <= 3'h0;
    repeat (3) @(posedge clock);
  endtask : pulse_in
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rd_stat("status after reset", 8'h10);
    chk("hresp", 8'h00, {7'h00, hresp});
    port_wr(3'h1, 8'h80);
    chk("cpu_reset", 8'h01, {7'h00, cpu_reset});
    repeat (CPU_RESET_HOLD_CYC) @(posedge clock);
    port_wr(3'h1, 8'h40);
    chk("reset and request", 8'h01, {6'h00, cpu_reset, cmd_request});
    port_wr(3'h1, 8'h30);
    chk("irq drive", 8'h03, {6'h00, u_tape_bus_if.irq_oe, u_tape_bus_if.irq_out});
    rd_stat("done enabled", 8'h90);
    port_wr(3'h1, 8'h20);
    rd_stat("done masked", 8'h10);
    chk("irq out masked", 8'h00, {7'h00, u_tape_bus_if.irq_out});
    port_wr(3'h1, 8'h00);
    chk("irq released", 8'h00, {7'h00, u_tape_bus_if.irq_oe});
    for (int i = 0; i < 8; i++) begin
      {chip_direction, chip_exception, chip_ready} <= 3'(i);
      @(posedge clock);
      rd_stat("status sources", {i[0] | i[1], i[0], i[1], 1'b1, i[2], 3'h0});
    end
    {chip_direction, chip_exception, chip_ready} <= 3'h0;
    port_wr(3'h1, 8'h30);
    port_wr(3'h0, CMD_READ);
    port_wr(3'h2, 8'hff);
    chk("launch", 8'h03, {6'h00, dma_active_ff, u_tape_bus_if.irq_oe});
    chk("launch pulses", 8'h01, 8'(pulse_cnt[0]));
    pulse_in(2);
    rd_stat("block done", 8'h90);
    port_wr(3'h3, 8'h55);
    chk("init pulses", 8'h01, 8'(pulse_cnt[1]));
    rd_stat("after init", 8'h10);
    port_wr(3'h1, 8'h80);
    repeat (CPU_RESET_HOLD_CYC) @(posedge clock);
    xfer(1'b1, AHB_OFS_CTRL, 32'h1);
    repeat (3) @(posedge clock);
    chk("cpu_reset after por", 8'h00, {7'h00, cpu_reset});
    for (int l = 4; l < 8; l++) port_wr(3'(l), 8'h30);
    chk("unused ignored", 8'h00, {7'h00, u_tape_bus_if.irq_oe});
    port_wr(3'h0, CMD_SELECT_LOCK);
    chk("select lock", 8'h03, {6'h00, drive_selected_ff, cartridge_locked_ff});
    port_wr(3'h0, CMD_SELECT);
    chk("select unlock", 8'h02, {6'h00, drive_selected_ff, cartridge_locked_ff});
    chk("command byte", CMD_SELECT, cmd_byte_ff);
    port_wr(3'h0, CMD_BOT);
    port_wr(3'h0, CMD_RETENSION);
    port_wr(3'h0, CMD_ERASE);
    chk("motion pulses", 8'h15, {2'h0, 2'(pulse_cnt[4]), 2'(pulse_cnt[3]), 2'(pulse_cnt[2])});
    port_wr(3'h0, CMD_WRITE);
    chk("writing", 8'h01, {7'h00, writing_ff});
    chip_ready <= 1'b1;
    port_wr(3'h0, CMD_FILEMARK_WRITE);
    chk("write ended", 8'h00, {7'h00, writing_ff});
    chip_ready <= 1'b0;
    port_wr(3'h0, CMD_WRITE);
    pulse_in(0);
    chk("end of media", 8'h01, {6'h00, writing_ff, end_of_media_ff});
    rd_stat("media exception", 8'hb0);
    port_wr(3'h0, CMD_READ);
    chk("reading", 8'h01, {7'h00, reading_ff});
    pulse_in(1);
    chk("read ended", 8'h00, {7'h00, reading_ff});
    rd_stat("filemark exception", 8'hb0);
    chip_direction <= 1'b1;
    chip_rdata <= 8'h5a;
    @(posedge clock);
    xfer(1'b0, AHB_OFS_DATA, 32'h0);
    chk("data read", 8'h5a, rd[7:0]);
    port_wr(3'h0, CMD_BOT);
    chk("write refused", CMD_READ, cmd_byte_ff);
    summarize();
  end
endmodule : tb
